// ---- hdl/icc_top.sv ----
// four input capture channels with capture fifos, flags and wake-up
// assumes both time bases count on i_sys_clk and the pins are asynchronous
//
// How it works
// - time_base_select_bit picks first or second time base; second after reset
// - both-edges mode raises the channel flag on every rising and falling edge
// - both-edges mode ignores events_per_interrupt_field
// - both-edges mode never sets capture_overflow_flag
// - interrupt-only mode with enable set wakes from sleep or idle, timer or not
// - in sleep the channel is only an interrupt source, no capture, no event count
// - in idle full function stays if timer enabled and stop_in_idle_bit clear
// - interrupt-only mode in idle makes the pin a pure interrupt input
// - events_per_interrupt_field, bits 6:5, sets captures per flag
// - per-channel flag and enable in shared registers; request only when enabled
// - each channel has a 16-bit buffer port and a control register reset to zero
// - four-word fifo per channel; each read shifts remaining words down
// - buffer_not_empty_flag sets on first capture, clears when all read
// - capture into full fifo is lost; outside both-edges mode it sets overflow and none taken until emptied
// - prescaler counter clears when channel is off and on reset
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps

module icc_top
  import icc_pkg::*;
#(
  parameter int NUM_CH = `ICC_NUM_CH,
  parameter int FIFO_DEPTH = `ICC_FIFO_DEPTH
)(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire icc_bus_t i_bus,
  output logic [15:0] o_rd_data,
  input wire logic [NUM_CH-1:0] i_capture_pin,
  input wire icc_tbase_t i_first_time_base,
  input wire icc_tbase_t i_second_time_base,
  input wire logic i_cpu_sleep,
  input wire logic i_cpu_idle,
  output logic o_irq,
  output logic o_wake
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the address map and flag registers are laid out for four channels
  if (NUM_CH != 4)
  begin : g_bad_ch
    $error("icc_top serves exactly four channels");
  end
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 7)
  begin : g_bad_depth
    $error("icc_top fifo depth must be 2 to 7");
  end

  localparam logic [`ICC_ADDR_W-1:0] BUF_OFS [4] = '{`ICC_BUF_CH1, `ICC_BUF_CH2, `ICC_BUF_CH7, `ICC_BUF_CH8};
  localparam logic [`ICC_ADDR_W-1:0] CTL_OFS [4] = '{`ICC_CTL_CH1, `ICC_CTL_CH2, `ICC_CTL_CH7, `ICC_CTL_CH8};
  localparam logic [2:0] DEPTH3 = 3'(FIFO_DEPTH);

  logic [NUM_CH-1:0] capture_interrupt_flag;
  logic [NUM_CH-1:0] capture_interrupt_enable;
  logic [NUM_CH-1:0] irq_evt;
  logic [15:0] ch_buf_rd [NUM_CH];
  logic [15:0] ch_ctl_rd [NUM_CH];

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    logic [2:0] pin_sync;
    logic pin_lvl;
    icc_ctrl_t ctrl;
    logic capture_overflow_flag;
    logic overflow_block;
    logic [3:0] pre_cnt;
    logic [1:0] evt_cnt;
    logic [2:0] fill;
    logic [15:0] fifo [FIFO_DEPTH];
    logic rise;
    logic fall;
    logic run;
    logic tb_on;
    logic [15:0] tb_count;
    logic qual;
    logic cap;
    logic push;
    logic pop;
    logic full;
    logic ovf_set;
    logic int_only;
    logic wr_ctl;
    logic [3:0] pre_last;
    logic evt;

    // register decode is per channel; a read of an empty buffer leaves fill alone
    assign wr_ctl = i_bus.wr && i_bus.addr == CTL_OFS[g];
    assign pop = i_bus.rd && i_bus.addr == BUF_OFS[g] && fill != 3'h0;

    // pin is asynchronous: three stages, a level counts once stages two and three agree
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        pin_sync <= 3'h0;
        pin_lvl <= 1'b0;
      end
      else if (i_clk_en)
      begin
        pin_sync <= {pin_sync[1:0], i_capture_pin[g]};
        if (pin_sync[1] == pin_sync[2])
        begin
          pin_lvl <= pin_sync[2];
        end
      end
    end

    assign rise = (pin_sync[1] == pin_sync[2]) && pin_sync[2] && !pin_lvl;
    assign fall = (pin_sync[1] == pin_sync[2]) && !pin_sync[2] && pin_lvl;

    // time base choice: one picks the first, zero (reset) the second
    assign tb_on = ctrl.tmr ? i_first_time_base.on : i_second_time_base.on;
    assign tb_count = ctrl.tmr ? i_first_time_base.count : i_second_time_base.count;

    // capture runs outside sleep, and in idle only with the timer on and no stop-in-idle
    assign run = !i_cpu_sleep && !(i_cpu_idle && (ctrl.sidl || !tb_on));
    assign pre_last = (ctrl.mode == `ICC_M_RISE4) ? `ICC_DIV4_LAST : `ICC_DIV16_LAST;

    always_comb
    begin
      case (ctrl.mode)
        `ICC_M_EVERY: qual = rise || fall;
        `ICC_M_FALL: qual = fall;
        `ICC_M_RISE: qual = rise;
        `ICC_M_RISE4: qual = rise && pre_cnt == pre_last;
        `ICC_M_RISE16: qual = rise && pre_cnt == pre_last;
        default: qual = 1'b0;
      endcase
    end

    // interrupt-only mode stores nothing and works in any cpu state, timer or not
    assign int_only = ctrl.mode == `ICC_M_IRQ_ONLY && rise;
    assign cap = run && qual;
    assign full = fill == DEPTH3;
    assign push = cap && !full && !overflow_block;
    assign ovf_set = cap && (full || overflow_block) && ctrl.mode != `ICC_M_EVERY;

    // the flag follows every capture in both-edges mode, even one lost to a full fifo;
    // otherwise it follows every ici+1 stored captures
    always_comb
    begin
      if (int_only)
      begin
        evt = 1'b1;
      end
      else if (ctrl.mode == `ICC_M_EVERY)
      begin
        evt = cap;
      end
      else
      begin
        evt = push && evt_cnt == ctrl.ici;
      end
    end
    assign irq_evt[g] = evt;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        ctrl <= icc_ctrl_t'(7'h00);
      end
      else if (i_clk_en && wr_ctl)
      begin
        ctrl.sidl <= i_bus.wdata[`ICC_B_SIDL];
        ctrl.tmr <= i_bus.wdata[`ICC_B_TMR];
        ctrl.ici <= i_bus.wdata[`ICC_B_ICI_HI:`ICC_B_ICI_LO];
        ctrl.mode <= i_bus.wdata[`ICC_B_MODE_HI:`ICC_B_MODE_LO];
      end
    end

    // overflow and not-empty are kept apart from ctrl and only merged in at readback
    // overflow is sticky; software clears it by writing zero, a new overflow wins
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        capture_overflow_flag <= 1'b0;
        overflow_block <= 1'b0;
      end
      else if (i_clk_en)
      begin
        if (ovf_set)
        begin
          capture_overflow_flag <= 1'b1;
        end
        else if (wr_ctl && !i_bus.wdata[`ICC_B_OV])
        begin
          capture_overflow_flag <= 1'b0;
        end
        if (ovf_set)
        begin
          overflow_block <= 1'b1;
        end
        else if (fill == 3'h0)
        begin
          overflow_block <= 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------
    // prescaler and event counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        pre_cnt <= 4'h0;
      end
      else if (i_clk_en)
      begin
        if (ctrl.mode == `ICC_M_OFF)
        begin
          pre_cnt <= 4'h0;
        end
        else if (run && rise && (ctrl.mode == `ICC_M_RISE4 || ctrl.mode == `ICC_M_RISE16))
        begin
          pre_cnt <= (pre_cnt == pre_last) ? 4'h0 : pre_cnt + 4'h1;
        end
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        evt_cnt <= 2'h0;
      end
      else if (i_clk_en)
      begin
        if (ctrl.mode == `ICC_M_OFF || wr_ctl)
        begin
          evt_cnt <= 2'h0;
        end
        else if (push && ctrl.mode != `ICC_M_EVERY)
        begin
          evt_cnt <= (evt_cnt == ctrl.ici) ? 2'h0 : evt_cnt + 2'h1;
        end
      end
    end

    // ----------------------------------------------------------------
    // capture fifo: head at entry zero, a read shifts the rest down
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        fill <= 3'h0;
      end
      else if (i_clk_en)
      begin
        fill <= fill + {2'h0, push} - {2'h0, pop};
      end
    end

    // data words carry no reset; an empty read returns whatever stands at the head
    always_ff @(posedge i_sys_clk)
    begin
      if (i_clk_en)
      begin
        for (int k = 0; k < FIFO_DEPTH; k++)
        begin
          if (push && 3'(k) == fill - {2'h0, pop})
          begin
            fifo[k] <= tb_count;
          end
          else if (pop && k < FIFO_DEPTH - 1)
          begin
            fifo[k] <= fifo[k + 1];
          end
        end
      end
    end

    assign ch_buf_rd[g] = fifo[0];
    always_comb
    begin
      ch_ctl_rd[g] = `ICC_CTL_RESET;
      ch_ctl_rd[g][`ICC_B_SIDL] = ctrl.sidl;
      ch_ctl_rd[g][`ICC_B_TMR] = ctrl.tmr;
      ch_ctl_rd[g][`ICC_B_ICI_HI:`ICC_B_ICI_LO] = ctrl.ici;
      ch_ctl_rd[g][`ICC_B_OV] = capture_overflow_flag;
      ch_ctl_rd[g][`ICC_B_BNE] = fill != 3'h0;
      ch_ctl_rd[g][`ICC_B_MODE_HI:`ICC_B_MODE_LO] = ctrl.mode;
    end
  end

  // ----------------------------------------------------------------
  // shared flag and enable registers
  // ----------------------------------------------------------------
  // flags clear by writing one; an event in the same cycle wins
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      capture_interrupt_flag <= '0;
    end
    else if (i_clk_en)
    begin
      if (i_bus.wr && i_bus.addr == `ICC_IFR)
      begin
        capture_interrupt_flag <= (capture_interrupt_flag & ~i_bus.wdata[NUM_CH-1:0]) | irq_evt;
      end
      else
      begin
        capture_interrupt_flag <= capture_interrupt_flag | irq_evt;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      capture_interrupt_enable <= '0;
    end
    else if (i_clk_en && i_bus.wr && i_bus.addr == `ICC_IER)
    begin
      capture_interrupt_enable <= i_bus.wdata[NUM_CH-1:0];
    end
  end

  assign o_irq = |(capture_interrupt_flag & capture_interrupt_enable);
  // a pending enabled request while sleeping or idling is the wake-up
  assign o_wake = o_irq && (i_cpu_sleep || i_cpu_idle);

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rd_data <= 16'h0000;
    end
    else if (i_clk_en && i_bus.rd)
    begin
      o_rd_data <= 16'h0000;
      // unmapped addresses read as zero, so software can probe the map safely
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (i_bus.addr == BUF_OFS[c])
        begin
          o_rd_data <= ch_buf_rd[c];
        end
        if (i_bus.addr == CTL_OFS[c])
        begin
          o_rd_data <= ch_ctl_rd[c];
        end
      end
      if (i_bus.addr == `ICC_IFR)
      begin
        o_rd_data <= {12'h000, capture_interrupt_flag};
      end
      if (i_bus.addr == `ICC_IER)
      begin
        o_rd_data <= {12'h000, capture_interrupt_enable};
      end
    end
  end

endmodule

// ---- inc/icc_params.svh ----
// constants of the four-channel input capture block: offsets, fields, codes
// assumes a 16-bit register port addressed with printed byte offsets
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ICC_ADDR_W 9
`define ICC_BUF_CH1 9'h140
`define ICC_CTL_CH1 9'h142
`define ICC_BUF_CH2 9'h144
`define ICC_CTL_CH2 9'h146
`define ICC_BUF_CH7 9'h158
`define ICC_CTL_CH7 9'h15a
`define ICC_BUF_CH8 9'h15c
`define ICC_CTL_CH8 9'h15e
`define ICC_IFR 9'h160
`define ICC_IER 9'h162

// ----------------------------------------------------------------
// control register fields and reset
// ----------------------------------------------------------------
`define ICC_CTL_RESET 16'h0000
`define ICC_B_SIDL 13
`define ICC_B_TMR 7
`define ICC_B_ICI_HI 6
`define ICC_B_ICI_LO 5
`define ICC_B_OV 4
`define ICC_B_BNE 3
`define ICC_B_MODE_HI 2
`define ICC_B_MODE_LO 0

// ----------------------------------------------------------------
// capture mode codes and prescaler terminal counts
// ----------------------------------------------------------------
`define ICC_M_OFF 3'h0
`define ICC_M_EVERY 3'h1
`define ICC_M_FALL 3'h2
`define ICC_M_RISE 3'h3
`define ICC_M_RISE4 3'h4
`define ICC_M_RISE16 3'h5
`define ICC_M_IRQ_ONLY 3'h7
`define ICC_DIV4_LAST 4'h3
`define ICC_DIV16_LAST 4'hf
`define ICC_FIFO_DEPTH 4
`define ICC_NUM_CH 4

`endif

// ---- inc/icc_pkg.sv ----
// types shared by the input capture block and its surroundings
// assumes icc_params.svh is on the include path
`include "icc_params.svh"

package icc_pkg;

  // ----------------------------------------------------------------
  // register port request, one cycle per access
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ICC_ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } icc_bus_t;

  // ----------------------------------------------------------------
  // one time base as seen by the channels
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic on;
  } icc_tbase_t;

  // ----------------------------------------------------------------
  // software-writable part of a channel control register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sidl;
    logic tmr;
    logic [1:0] ici;
    logic [2:0] mode;
  } icc_ctrl_t;

endpackage

// ---- bench/icc_sva.sv ----
// checker for the four-channel capture block, watching its top ports only
// assumes the register map header and a bind onto icc_top
`timescale 1ns/100ps
`include "icc_params.svh"
module icc_sva
  import icc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int FIFO_DEPTH = 4
)(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire icc_bus_t i_bus,
  input wire logic [15:0] o_rd_data,
  input wire logic [NUM_CH-1:0] i_capture_pin,
  input wire icc_tbase_t i_first_time_base,
  input wire icc_tbase_t i_second_time_base,
  input wire logic i_cpu_sleep,
  input wire logic i_cpu_idle,
  input wire logic o_irq,
  input wire logic o_wake
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic mapped;
  logic [15:0] ctl1_w;
  logic lowp;
  assign lowp = i_cpu_sleep || i_cpu_idle;
  assign mapped = (i_bus.addr inside {[9'h140:9'h146], [9'h158:9'h162]}) && !i_bus.addr[0];
  // shadow of the last channel 1 control write, for readback
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
    if (!i_reset_n)
      ctl1_w <= 16'h0000;
    else if (i_clk_en && i_bus.wr && i_bus.addr == `ICC_CTL_CH1)
      ctl1_w <= i_bus.wdata;
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  a_wake_needs_irq: assert property (o_wake |-> o_irq && lowp) else $error("wake without cause");
  a_wake_follows: assert property (o_irq && lowp |-> o_wake) else $error("no wake");
  a_mask_clears: assert property (i_clk_en && i_bus.wr && i_bus.addr == `ICC_IER && i_bus.wdata[3:0] == 4'h0
    |=> !o_irq) else $error("irq with enables off");
  a_flag_clear: assert property ($stable(i_capture_pin)[*6] ##0 (i_clk_en && i_bus.wr &&
    i_bus.addr == `ICC_IFR && i_bus.wdata[3:0] == 4'hf) |=> !o_irq) else $error("irq after clear");
  a_unmapped_zero: assert property (i_clk_en && i_bus.rd && !mapped |=> o_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_bus.wr) ||
    $past(i_capture_pin, 3) != $past(i_capture_pin, 6)) else $error("irq without pin edge");
  a_reset_quiet: assert property ($rose(i_reset_n) |-> !o_irq && !o_wake && o_rd_data == 16'h0000)
    else $error("outputs not quiet after reset");
  a_ctl_readback: assert property (i_clk_en && i_bus.rd && i_bus.addr == `ICC_CTL_CH1
    |=> (o_rd_data & 16'h20e7) == (ctl1_w & 16'h20e7)) else $error("control readback");
endmodule

bind icc_top icc_sva #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH)) icc_sva_i (.i_sys_clk, .i_reset_n, .i_clk_en,
  .i_bus, .o_rd_data, .i_capture_pin, .i_first_time_base, .i_second_time_base, .i_cpu_sleep, .i_cpu_idle,
  .o_irq, .o_wake);

// ---- bench/icc_sensor.sv ----
// pulse or hall sensor model driving the four capture pins
// assumes the bench calls drive once per level change
`timescale 1ns/100ps
module icc_sensor (
  input wire logic i_sys_clk,
  output logic [3:0] o_pins
);
  initial o_pins = 4'h0;
  // each level is held six edges so the synchroniser always sees it settle
  task automatic drive(input int ch, input logic lv);
    @(posedge i_sys_clk);
    o_pins[ch] <= lv;
    repeat (5) @(posedge i_sys_clk);
  endtask
endmodule

// ---- bench/icc_top_tb.sv ----
// self-checking bench for the four-channel capture block
// assumes icc_top, the sensor model and the bound checker
`timescale 1ns/100ps
`include "icc_params.svh"
module icc_top_tb
  import icc_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  icc_bus_t i_bus = '0;
  icc_tbase_t first_base = '{16'h0000, 1'b1};
  icc_tbase_t second_base = '{16'h0000, 1'b1};
  logic sleep = 1'b0;
  logic idle = 1'b0;
  logic [3:0] pins;
  logic [15:0] rd_data;
  logic irq;
  logic wake;
  logic [15:0] got;
  int mismatches = 0;
  int samples_checked = 0;
  logic [8:0] ctla [4] = '{`ICC_CTL_CH1, `ICC_CTL_CH2, `ICC_CTL_CH7, `ICC_CTL_CH8};
  logic [2:0] mtab [4] = '{`ICC_M_RISE4, `ICC_M_RISE16, `ICC_M_FALL, `ICC_M_RISE};
  int ntab [4] = '{4, 16, 1, 1};
  icc_top icc_top_i (.i_sys_clk, .i_reset_n, .i_clk_en(1'b1), .i_bus, .o_rd_data(rd_data), .i_capture_pin(pins),
    .i_first_time_base(first_base), .i_second_time_base(second_base), .i_cpu_sleep(sleep), .i_cpu_idle(idle),
    .o_irq(irq), .o_wake(wake));
  icc_sensor icc_sensor_i (.i_sys_clk, .o_pins(pins));
  initial forever #10 i_sys_clk = ~i_sys_clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ctl(input logic sidl, tmr, input logic [1:0] ici, input logic ov, bne,
    input logic [2:0] m);
    return {2'h0, sidl, 5'h00, tmr, ici, ov, bne, m};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_bus <= '{1'b1, 1'b0, a, d};
    @(posedge i_sys_clk);
    i_bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge i_sys_clk);
    i_bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge i_sys_clk);
    i_bus.rd <= 1'b0;
    @(posedge i_sys_clk);
    got = rd_data;
  endtask
  // counts stand still while the edge lands; second base is the inverse
  task automatic edge1(input int ch, input logic lv, input logic [15:0] t);
    first_base.count <= t;
    second_base.count <= ~t;
    icc_sensor_i.drive(ch, lv);
  endtask
  task automatic pulse(input int ch, input logic [15:0] t);
    edge1(ch, 1'b1, t);
    edge1(ch, 1'b0, t);
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge i_sys_clk);
    mismatches++;
    report_and_stop;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] v [6];
    int n;
    n = $urandom(32'h09aa_8e09);
    repeat (6) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    foreach (ctla[c])
    begin
      rd(ctla[c]);
      chk("ctl reset", 16'h0000, got);
    end
    rd(9'h150);
    chk("unmapped", 16'h0000, got);
    $display("test reset done");
    wr(`ICC_CTL_CH1, ctl(0, 0, 2'h0, 0, 0, `ICC_M_RISE));
    for (int i = 0; i < 5; i++)
    begin
      v[i] = 16'($urandom);
      pulse(0, v[i]);
    end
    rd(`ICC_CTL_CH1);
    chk("ctl full", ctl(0, 0, 2'h0, 1, 1, `ICC_M_RISE), got);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        pulse(0, 16'h5a5a);
      rd(`ICC_BUF_CH1);
      chk("fifo word", ~v[i], got);
    end
    rd(`ICC_CTL_CH1);
    chk("ctl drained", ctl(0, 0, 2'h0, 1, 0, `ICC_M_RISE), got);
    $display("test fifo done");
    wr(`ICC_IFR, 16'h000f);
    wr(`ICC_IER, 16'h0002);
    wr(`ICC_CTL_CH2, ctl(0, 1, 2'h3, 0, 0, `ICC_M_EVERY));
    for (int i = 0; i < 6; i++)
    begin
      v[i] = 16'($urandom);
      edge1(1, ~i[0], v[i]);
      chk("edge irq", 16'h0001, {15'h0000, irq});
      rd(`ICC_IFR);
      chk("edge flag", 16'h0002, got);
      wr(`ICC_IFR, 16'h0002);
    end
    rd(`ICC_CTL_CH2);
    chk("hall ctl", ctl(0, 1, 2'h3, 0, 1, `ICC_M_EVERY), got);
    for (int i = 0; i < 4; i++)
    begin
      rd(`ICC_BUF_CH2);
      chk("hall word", v[i], got);
    end
    $display("test hall done");
    wr(`ICC_IER, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      wr(`ICC_CTL_CH7, ctl(0, 1, k[1:0], 0, 0, `ICC_M_RISE));
      wr(`ICC_IFR, 16'h000f);
      for (int i = 0; i <= k; i++)
      begin
        rd(`ICC_IFR);
        chk("early flag", 16'h0000, got);
        pulse(2, 16'($urandom));
      end
      rd(`ICC_IFR);
      chk("count flag", 16'h0004, got);
      chk("masked irq", 16'h0000, {15'h0000, irq});
      repeat (4) rd(`ICC_BUF_CH7);
    end
    $display("test count done");
    wr(`ICC_CTL_CH8, ctl(0, 1, 2'h0, 0, 0, `ICC_M_RISE4));
    repeat (2) pulse(3, 16'h0000);
    wr(`ICC_CTL_CH8, ctl(0, 1, 2'h0, 0, 0, `ICC_M_OFF));
    foreach (mtab[j])
    begin
      wr(`ICC_CTL_CH8, ctl(0, 1, 2'h0, 0, 0, mtab[j]));
      wr(`ICC_IFR, 16'h000f);
      repeat (ntab[j] - 1) pulse(3, 16'h0000);
      rd(`ICC_IFR);
      chk("pre flag", 16'h0000, got);
      pulse(3, 16'h0000);
      rd(`ICC_IFR);
      chk("mode flag", 16'h0008, got);
      rd(`ICC_BUF_CH8);
    end
    $display("test prescale done");
    wr(`ICC_IFR, 16'h000f);
    wr(`ICC_IER, 16'h0001);
    wr(`ICC_CTL_CH1, ctl(0, 0, 2'h0, 0, 0, `ICC_M_IRQ_ONLY));
    first_base.on <= 1'b0;
    second_base.on <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      sleep <= (s == 0);
      idle <= (s == 1);
      pulse(0, 16'h0000);
      chk("wake", 16'h0001, {15'h0000, wake});
      rd(`ICC_CTL_CH1);
      chk("no capture", ctl(0, 0, 2'h0, 0, 0, `ICC_M_IRQ_ONLY), got);
      wr(`ICC_IFR, 16'h0001);
    end
    // idle: full function only with the second base running and stop-in-idle clear
    for (int s = 0; s < 3; s++)
    begin
      second_base.on <= (s != 2);
      wr(`ICC_CTL_CH1, ctl(s == 1, 0, 2'h0, 0, 0, `ICC_M_RISE));
      pulse(0, v[0]);
      rd(`ICC_CTL_CH1);
      chk("idle ctl", ctl(s == 1, 0, 2'h0, 0, s == 0, `ICC_M_RISE), got);
      rd(`ICC_BUF_CH1);
    end
    idle <= 1'b0;
    $display("test low power done");
    // a reset in mid-run brings every channel back to its reset state
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    foreach (ctla[c])
    begin
      rd(ctla[c]);
      chk("ctl re-reset", 16'h0000, got);
    end
    rd(`ICC_IER);
    chk("ier re-reset", 16'h0000, got);
    $display("test re-reset done");
    report_and_stop;
  end
endmodule
